// ### verilog/loe_pkg.sv
package loe_pkg;

    //------------------------------------------------------------
    // Operation and addressing forms
    //------------------------------------------------------------
    typedef enum logic [3:0] {
        LOE_M_IMM,      // working byte, immediate
        LOE_M_SD_IMM,   // short-direct, immediate
        LOE_M_A_R,      // working byte, register slot
        LOE_M_R_A,      // register slot, working byte
        LOE_M_A_SD,     // working byte, short-direct
        LOE_M_A_ABS,    // working byte, absolute operand
        LOE_M_A_PP,     // working byte, pointer pair
        LOE_M_A_PPOFS,  // pointer pair plus offset
        LOE_M_A_PPB,    // pointer pair plus index one
        LOE_M_A_PPC     // pointer pair plus index two
    } loe_mode_t;

    // Working byte sits in slot 1 of the register bank
    localparam logic [2:0] LOE_SLOT_WORK = 3'h1;
    localparam logic [2:0] LOE_SLOT_IDX1 = 3'h3;
    localparam logic [2:0] LOE_SLOT_IDX2 = 3'h2;
    localparam logic [2:0] LOE_SLOT_PPLO = 3'h6;
    localparam logic [2:0] LOE_SLOT_PPHI = 3'h7;

    // Instruction lengths in bytes
    localparam logic [1:0] LOE_LEN_1 = 2'h1;
    localparam logic [1:0] LOE_LEN_2 = 2'h2;
    localparam logic [1:0] LOE_LEN_3 = 2'h3;

    // Clock counts: fast area / other area
    localparam logic [3:0] LOE_CLK_4 = 4'h4;
    localparam logic [3:0] LOE_CLK_5 = 4'h5;
    localparam logic [3:0] LOE_CLK_6 = 4'h6;
    localparam logic [3:0] LOE_CLK_8 = 4'h8;
    localparam logic [3:0] LOE_CLK_9 = 4'h9;

    // Short-direct page base and reset values
    localparam logic [7:0] LOE_SD_PAGE  = 8'hFE;
    localparam logic [7:0] LOE_RST_BYTE = 8'h00;

endpackage

// ### verilog/loe_mem_if.sv
`timescale 1ns/10ps
// Data access channel between sequencer and memory port stage
interface loe_mem_if;
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        done;

    modport seq (output req, output we, output addr, output wdata, input rdata, input done);
    modport port (input req, input we, input addr, input wdata, output rdata, output done);
endinterface

// ### verilog/loe_mem_port.sv
`timescale 1ns/10ps
// Registers one data access onto the memory pins and returns its read byte
module loe_mem_port (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Sequencer side
    loe_mem_if.port          mi,
    // Memory pins
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata
);
    logic       busy_q;
    logic [7:0] rd_q;

    // Read byte passes straight through while the strobe stands, then the held copy
    assign mi.rdata = mem_rd ? mem_rdata : rd_q;
    assign mi.done  = busy_q;

    // Drive strobe for one cycle; keep the read byte, never the bus during a write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_q    <= 1'b0;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_addr  <= 16'h0000;
            mem_wdata <= loe_pkg::LOE_RST_BYTE;
            rd_q      <= loe_pkg::LOE_RST_BYTE;
        end else if (clk_en) begin
            mem_rd    <= mi.req && !mi.we && !busy_q;
            mem_wr    <= mi.req && mi.we && !busy_q;
            if (mi.req && !busy_q) begin
                mem_addr  <= mi.addr;
                mem_wdata <= mi.wdata;
            end
            busy_q <= mi.req && !busy_q;
            if (mem_rd) begin
                rd_q <= mem_rdata;
            end
        end
    end
endmodule

// ### verilog/loe_core.sv
`timescale 1ns/10ps
module loe_core #(
    parameter logic [15:0] HS_RAM_LO = 16'hFB00,
    parameter logic [15:0] HS_RAM_HI = 16'hFEFF
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Instruction issue
    input  wire logic        start,
    input  wire logic        op_xor,
    input  wire logic [3:0]  mode,
    input  wire logic [2:0]  slot,
    input  wire logic [7:0]  imm,
    input  wire logic [7:0]  sd_addr,
    input  wire logic [15:0] abs_addr,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    output logic [1:0]       inst_len,
    output logic [3:0]       inst_clocks,
    // Register bank view
    output logic [7:0]       work_byte,
    output logic             zero_flag,
    output logic             half_carry_flag,
    output logic             carry_flag,
    input  wire logic [7:0]  hc_cy_init,
    // Memory pins
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata
);
    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    typedef enum logic [2:0] {LOE_S_IDLE, LOE_S_READ, LOE_S_WRITE, LOE_S_WAIT} loe_state_t;

    loe_state_t       st_q;
    logic [7:0]       rf_q [8];
    logic [7:0]       opd_q;
    logic [15:0]      ea_q;
    logic [3:0]       cnt_q;
    logic [3:0]       need_q;
    logic             xor_q;
    logic [3:0]       mode_q;
    logic [2:0]       slot_q;
    logic             z_q;
    logic             hc_q;
    logic             cy_q;
    logic             done_q;
    logic             ill_q;
    logic [1:0]       len_q;
    loe_mem_if        mi ();

    // Pointer pair and effective address
    wire  [15:0]      ptr_pair = {rf_q[loe_pkg::LOE_SLOT_PPHI], rf_q[loe_pkg::LOE_SLOT_PPLO]};
    wire  [15:0]      sd_ea    = {loe_pkg::LOE_SD_PAGE, sd_addr};
    wire  [15:0]      ea;
    wire              has_mem;
    wire              is_rmw;
    wire              reg_form;
    wire              bad;
    wire  [3:0]       clk_need;
    wire  [1:0]       len;
    wire  [7:0]       src;
    wire  [7:0]       dst;
    wire  [7:0]       res;

    // Logic operation shared by every form
    function automatic logic [7:0] loe_alu(input logic x, input logic [7:0] a, input logic [7:0] b);
        loe_alu = x ? (a ^ b) : (a | b);
    endfunction

    // Fast area test
    function automatic logic loe_fast(input logic [15:0] ad);
        loe_fast = (ad >= HS_RAM_LO) && (ad <= HS_RAM_HI);
    endfunction

    //------------------------------------------------------------
    // Instruction decode
    //------------------------------------------------------------
    assign ea = (mode == loe_pkg::LOE_M_SD_IMM || mode == loe_pkg::LOE_M_A_SD) ? sd_ea :
                (mode == loe_pkg::LOE_M_A_ABS)   ? abs_addr :
                (mode == loe_pkg::LOE_M_A_PP)    ? ptr_pair :
                (mode == loe_pkg::LOE_M_A_PPOFS) ? ptr_pair + {8'h00, imm} :
                (mode == loe_pkg::LOE_M_A_PPB)   ? ptr_pair + {8'h00, rf_q[loe_pkg::LOE_SLOT_IDX1]} :
                ptr_pair + {8'h00, rf_q[loe_pkg::LOE_SLOT_IDX2]};
    assign reg_form = (mode == loe_pkg::LOE_M_A_R) || (mode == loe_pkg::LOE_M_R_A);
    assign has_mem  = (mode != loe_pkg::LOE_M_IMM) && !reg_form;
    assign is_rmw   = (mode == loe_pkg::LOE_M_SD_IMM);
    assign bad      = (mode == loe_pkg::LOE_M_A_R && slot == loe_pkg::LOE_SLOT_WORK)
                      || (mode > loe_pkg::LOE_M_A_PPC);

    // Length per form
    assign len = (mode == loe_pkg::LOE_M_SD_IMM || mode == loe_pkg::LOE_M_A_ABS) ? loe_pkg::LOE_LEN_3 :
                 (mode == loe_pkg::LOE_M_A_PP) ? loe_pkg::LOE_LEN_1 :
                 loe_pkg::LOE_LEN_2;

    // Clock count: low in fast area or with no access, high elsewhere
    assign clk_need =
        !has_mem ? loe_pkg::LOE_CLK_4 :
        is_rmw ? (loe_fast(ea) ? loe_pkg::LOE_CLK_6 : loe_pkg::LOE_CLK_8) :
        (mode == loe_pkg::LOE_M_A_SD || mode == loe_pkg::LOE_M_A_PP) ?
            (loe_fast(ea) ? loe_pkg::LOE_CLK_4 : loe_pkg::LOE_CLK_5) :
        (loe_fast(ea) ? loe_pkg::LOE_CLK_8 : loe_pkg::LOE_CLK_9);

    //------------------------------------------------------------
    // Execute: operand select and result
    //------------------------------------------------------------
    assign src = (mode_q == loe_pkg::LOE_M_IMM || mode_q == loe_pkg::LOE_M_SD_IMM) ? opd_q :
                 (mode_q == loe_pkg::LOE_M_A_R || mode_q == loe_pkg::LOE_M_R_A) ? rf_q[slot_q] : opd_q;
    assign dst = (mode_q == loe_pkg::LOE_M_SD_IMM) ? mi.rdata :
                 (mode_q == loe_pkg::LOE_M_R_A) ? rf_q[slot_q] : rf_q[loe_pkg::LOE_SLOT_WORK];
    assign res = loe_alu(xor_q, dst, (mode_q == loe_pkg::LOE_M_R_A) ? rf_q[loe_pkg::LOE_SLOT_WORK] :
                 (mode_q == loe_pkg::LOE_M_SD_IMM) ? opd_q : src);

    assign mi.req   = (st_q == LOE_S_READ) || (st_q == LOE_S_WRITE);
    assign mi.we    = (st_q == LOE_S_WRITE);
    assign mi.addr  = ea_q;
    assign mi.wdata = res;

    //------------------------------------------------------------
    // Sequencer, one count per CPU clock
    //------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q   <= LOE_S_IDLE;
            opd_q  <= loe_pkg::LOE_RST_BYTE;
            ea_q   <= 16'h0000;
            cnt_q  <= 4'h0;
            need_q <= 4'h0;
            xor_q  <= 1'b0;
            mode_q <= 4'h0;
            slot_q <= 3'h0;
            z_q    <= 1'b0;
            hc_q   <= 1'b0;
            cy_q   <= 1'b0;
            done_q <= 1'b0;
            ill_q  <= 1'b0;
            len_q  <= 2'h0;
            for (int i = 0; i < 8; i++) begin
                rf_q[i] <= loe_pkg::LOE_RST_BYTE;
            end
        end else if (clk_en) begin
            done_q <= 1'b0;
            ill_q  <= 1'b0;
            case (st_q)
                LOE_S_IDLE: begin
                    if (start && bad) begin
                        ill_q <= 1'b1;
                    end else if (start) begin
                        xor_q  <= op_xor;
                        mode_q <= mode;
                        slot_q <= slot;
                        ea_q   <= ea;
                        opd_q  <= imm;
                        need_q <= clk_need;
                        len_q  <= len;
                        cnt_q  <= 4'h1;
                        st_q   <= has_mem ? LOE_S_READ : LOE_S_WAIT;
                    end
                end
                LOE_S_READ: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (mi.done) begin
                        if (mode_q != loe_pkg::LOE_M_SD_IMM) begin
                            opd_q <= mi.rdata;
                        end
                        st_q <= is_rmw_q() ? LOE_S_WRITE : LOE_S_WAIT;
                    end
                end
                LOE_S_WRITE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (mi.done) begin
                        st_q <= LOE_S_WAIT;
                    end
                end
                LOE_S_WAIT: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q >= need_q - 4'h1) begin
                        // Retire: write back and zero flag
                        if (mode_q == loe_pkg::LOE_M_R_A) begin
                            rf_q[slot_q] <= res;
                        end else if (mode_q != loe_pkg::LOE_M_SD_IMM) begin
                            rf_q[loe_pkg::LOE_SLOT_WORK] <= res;
                        end
                        z_q    <= (res == 8'h00);
                        done_q <= 1'b1;
                        st_q   <= LOE_S_IDLE;
                    end
                end
                default: st_q <= LOE_S_IDLE;
            endcase
        end
    end

    // Read-modify-write test on the latched form
    function automatic logic is_rmw_q();
        is_rmw_q = (mode_q == loe_pkg::LOE_M_SD_IMM);
    endfunction

    //------------------------------------------------------------
    // Memory port stage
    //------------------------------------------------------------
    loe_mem_port u_port (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .mi        (mi.port),
        .mem_rd    (mem_rd),
        .mem_wr    (mem_wr),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata)
    );

    // Outputs
    assign busy            = (st_q != LOE_S_IDLE);
    assign done            = done_q;
    assign illegal         = ill_q;
    assign inst_len        = len_q;
    assign inst_clocks     = need_q;
    assign work_byte       = rf_q[loe_pkg::LOE_SLOT_WORK];
    assign zero_flag       = z_q;
    assign half_carry_flag = hc_q;
    assign carry_flag      = cy_q;
    wire unused_init = ^hc_cy_init;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    property p_len_one;
        @(posedge sys_clk) disable iff (!rst_n)
        start && !busy && mode == loe_pkg::LOE_M_A_PP && !bad |-> len == loe_pkg::LOE_LEN_1;
    endproperty
    a_len_one: assert property (p_len_one) else $error("pointer form length wrong");
    property p_nomem_four;
        @(posedge sys_clk) disable iff (!rst_n)
        start && !busy && !bad && clk_en && (mode == loe_pkg::LOE_M_IMM) |-> clk_need == loe_pkg::LOE_CLK_4;
    endproperty
    a_nomem_four: assert property (p_nomem_four) else $error("no-access count not four");
    property p_illegal;
        @(posedge sys_clk) disable iff (!rst_n)
        start && !busy && clk_en && mode == loe_pkg::LOE_M_A_R && slot == loe_pkg::LOE_SLOT_WORK
        |=> illegal && !busy;
    endproperty
    a_illegal: assert property (p_illegal) else $error("excluded form not refused");
    property p_flags_kept;
        @(posedge sys_clk) disable iff (!rst_n)
        done |-> $stable(half_carry_flag) && $stable(carry_flag);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("carry flags changed");
    property p_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        done && mode_q != loe_pkg::LOE_M_SD_IMM && mode_q != loe_pkg::LOE_M_R_A
        |-> zero_flag == (work_byte == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");
    property p_no_access;
        @(posedge sys_clk) disable iff (!rst_n)
        start && !busy && clk_en && !bad && !has_mem |-> ##1 (!mem_rd && !mem_wr) [*4];
    endproperty
    a_no_access: assert property (p_no_access) else $error("register form touched memory");
    property p_rd_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        mem_rd && clk_en |=> !mem_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than one cycle");
    property p_done_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        done && clk_en |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    c_rmw: cover property (@(posedge sys_clk) mem_wr);
    c_xor: cover property (@(posedge sys_clk) done && xor_q);
    c_ill: cover property (@(posedge sys_clk) illegal);
endmodule

// ### test/loe_mem_model.sv
`timescale 1ns/10ps
// Behavioural data memory and short-direct space on the far side of the core
module loe_mem_model (
    // Clock
    input  wire logic        sys_clk,
    // Memory pins
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata
);
    logic [7:0]  mem [0:65535];
    logic        rd_q     = 1'h0;
    logic [15:0] addr_q   = 16'h0000;
    logic [7:0]  noise_q  = 8'hA5;
    int          wr_count = 0;

    //------------------------------------------------------------
    // Storage and read timing
    //------------------------------------------------------------
    // Writes land on the strobe edge; the read address is kept one extra cycle
    always @(posedge sys_clk) begin
        rd_q    <= mem_rd;
        addr_q  <= mem_addr;
        noise_q <= noise_q + 8'h3B;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
            wr_count      <= wr_count + 1;
        end
    end

    // Data is valid in the strobe cycle and the one after, noise otherwise
    assign mem_rdata = mem_rd ? mem[mem_addr] : (rd_q ? mem[addr_q] : noise_q);
endmodule

// ### test/logic_op_execute_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the logical operation core
module logic_op_execute_tb_top;
    typedef struct packed {
        logic        x;
        logic [3:0]  m;
        logic [2:0]  s;
        logic [7:0]  imm;
        logic [7:0]  sd;
        logic [15:0] ab;
        logic [7:0]  a;
        logic        z;
        logic [1:0]  len;
        logic [3:0]  clk;
    } loe_row_t;

    //------------------------------------------------------------
    // Instruction table: operation, operands, expected results
    //------------------------------------------------------------
    localparam loe_row_t ROWS [29] = '{
        '{1'h0, 4'h0, 3'h0, 8'h10, 8'h00, 16'h0000, 8'h10, 1'h0, 2'h2, 4'h4},
        '{1'h0, 4'h3, 3'h6, 8'h00, 8'h00, 16'h0000, 8'h10, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h0, 3'h0, 8'hEC, 8'h00, 16'h0000, 8'hFC, 1'h0, 2'h2, 4'h4},
        '{1'h0, 4'h3, 3'h7, 8'h00, 8'h00, 16'h0000, 8'hFC, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h0, 3'h0, 8'hFC, 8'h00, 16'h0000, 8'h00, 1'h1, 2'h2, 4'h4},
        '{1'h0, 4'h6, 3'h0, 8'h00, 8'h00, 16'h0000, 8'h03, 1'h0, 2'h1, 4'h4},
        '{1'h0, 4'h3, 3'h3, 8'h00, 8'h00, 16'h0000, 8'h03, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h7, 3'h0, 8'h05, 8'h00, 16'h0000, 8'h43, 1'h0, 2'h2, 4'h8},
        '{1'h0, 4'h8, 3'h0, 8'h00, 8'h00, 16'h0000, 8'h4F, 1'h0, 2'h2, 4'h8},
        '{1'h1, 4'h9, 3'h0, 8'h00, 8'h00, 16'h0000, 8'h4C, 1'h0, 2'h2, 4'h8},
        '{1'h0, 4'h5, 3'h0, 8'h00, 8'h00, 16'h1234, 8'h7C, 1'h0, 2'h3, 4'h9},
        '{1'h1, 4'h5, 3'h0, 8'h00, 8'h00, 16'hFB00, 8'h00, 1'h1, 2'h3, 4'h8},
        '{1'h0, 4'h1, 3'h0, 8'h80, 8'h20, 16'h0000, 8'h00, 1'h0, 2'h3, 4'h6},
        '{1'h1, 4'h4, 3'h0, 8'h00, 8'h20, 16'h0000, 8'h81, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h1, 3'h0, 8'hFF, 8'h20, 16'h0000, 8'h81, 1'h0, 2'h3, 4'h6},
        '{1'h0, 4'h4, 3'h0, 8'h00, 8'h20, 16'h0000, 8'hFF, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h2, 3'h3, 8'h00, 8'h00, 16'h0000, 8'hFC, 1'h0, 2'h2, 4'h4},
        '{1'h0, 4'h2, 3'h2, 8'h00, 8'h00, 16'h0000, 8'hFC, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h3, 3'h2, 8'h00, 8'h00, 16'h0000, 8'hFC, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h2, 3'h2, 8'h00, 8'h00, 16'h0000, 8'h00, 1'h1, 2'h2, 4'h4},
        '{1'h1, 4'h6, 3'h0, 8'h00, 8'h00, 16'h0000, 8'h03, 1'h0, 2'h1, 4'h4},
        '{1'h0, 4'h7, 3'h0, 8'h05, 8'h00, 16'h0000, 8'h43, 1'h0, 2'h2, 4'h8},
        '{1'h1, 4'h8, 3'h0, 8'h00, 8'h00, 16'h0000, 8'h4F, 1'h0, 2'h2, 4'h8},
        '{1'h0, 4'h9, 3'h0, 8'h00, 8'h00, 16'h0000, 8'hFF, 1'h0, 2'h2, 4'h8},
        '{1'h1, 4'h0, 3'h0, 8'h11, 8'h00, 16'h0000, 8'hEE, 1'h0, 2'h2, 4'h4},
        '{1'h1, 4'h3, 3'h7, 8'h00, 8'h00, 16'h0000, 8'hEE, 1'h0, 2'h2, 4'h4},
        '{1'h0, 4'h6, 3'h0, 8'h00, 8'h00, 16'h0000, 8'hEF, 1'h0, 2'h1, 4'h5},
        '{1'h1, 4'h7, 3'h0, 8'h24, 8'h00, 16'h0000, 8'hDF, 1'h0, 2'h2, 4'h9},
        '{1'h0, 4'h0, 3'h0, 8'hFF, 8'h00, 16'h0000, 8'hFF, 1'h0, 2'h2, 4'h4}
    };

    logic        sys_clk = 1'h0;
    logic        rst_n, clk_en, start, op_xor;
    logic [3:0]  mode;
    logic [2:0]  slot;
    logic [7:0]  imm, sd_addr, hc_cy_init, work_byte, mem_wdata, mem_rdata;
    logic [15:0] abs_addr, mem_addr;
    logic        busy, done, illegal, zero_flag, half_carry_flag, carry_flag, mem_rd, mem_wr;
    logic [1:0]  inst_len;
    logic [3:0]  inst_clocks;
    int          error_cnt   = 0;
    int          check_count = 0;
    int          n;
    logic        seen;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    //------------------------------------------------------------
    // Design and far-side memory
    //------------------------------------------------------------
    loe_core u_loe_core (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .start(start), .op_xor(op_xor),
        .mode(mode), .slot(slot), .imm(imm), .sd_addr(sd_addr), .abs_addr(abs_addr), .busy(busy), .done(done),
        .illegal(illegal), .inst_len(inst_len), .inst_clocks(inst_clocks), .work_byte(work_byte),
        .zero_flag(zero_flag), .half_carry_flag(half_carry_flag), .carry_flag(carry_flag),
        .hc_cy_init(hc_cy_init), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    loe_mem_model u_mem (.sys_clk(sys_clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    //------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------
    task automatic complete_run();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'h1) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    // Issue one instruction; gap freezes the core, hold keeps start up while busy
    task automatic run(input loe_row_t r, input int gap, input logic hold, output int cnt);
        @(negedge sys_clk);
        start    = 1'h1;
        op_xor   = r.x;
        mode     = r.m;
        slot     = r.s;
        imm      = r.imm;
        sd_addr  = r.sd;
        abs_addr = r.ab;
        @(posedge sys_clk);
        cnt = 0;
        while (cnt < 30) begin
            @(negedge sys_clk);
            cnt++;
            if (done === 1'h1) break;
            start  = hold;
            clk_en = (cnt > gap) ? 1'h1 : 1'h0;
        end
        start  = 1'h0;
        clk_en = 1'h1;
        if (done !== 1'h1) begin
            error_cnt++;
            $display("FAIL %0t no completion", $time);
            complete_run();
        end
    endtask

    // Issue an excluded form and watch for the refusal pulse
    task automatic refuse(input logic [3:0] m, input logic [2:0] s);
        @(negedge sys_clk);
        start = 1'h1;
        mode  = m;
        slot  = s;
        seen  = 1'h0;
        repeat (3) begin
            @(negedge sys_clk);
            start = 1'h0;
            if (illegal === 1'h1) seen = 1'h1;
        end
        chk(seen, "refusal pulse missing");
        chk(work_byte === 8'h21 && done === 1'h0, "refused form had an effect");
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial begin
        {rst_n, start, op_xor, mode, slot, imm, sd_addr, abs_addr} = '0;
        hc_cy_init = 8'hFF;
        u_mem.mem[16'hFC10] = 8'h03;
        u_mem.mem[16'hFC15] = 8'h40;
        u_mem.mem[16'hFC13] = 8'h0C;
        u_mem.mem[16'hFD0C] = 8'hB0;
        u_mem.mem[16'h1234] = 8'h30;
        u_mem.mem[16'hFB00] = 8'h7C;
        u_mem.mem[16'hFE20] = 8'h01;
        u_mem.mem[16'h1210] = 8'h01;
        clk_en = 1'h1;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'h1;
        chk({busy, done, illegal, inst_len, inst_clocks, work_byte, zero_flag, mem_rd, mem_wr} === '0, "reset");
        chk({half_carry_flag, carry_flag} === 2'h0, "flags after reset");
        for (int i = 0; i < 29; i++) begin
            run(ROWS[i], 0, 1'h0, n);
            chk(n == int'(ROWS[i].clk), "clock count");
            chk(inst_len === ROWS[i].len && inst_clocks === ROWS[i].clk, "length or count");
            chk(work_byte === ROWS[i].a, "working byte");
            chk(zero_flag === ROWS[i].z && {half_carry_flag, carry_flag} === 2'h0, "flags");
        end
        chk(u_mem.mem[16'hFE20] === 8'h7E, "short-direct write back");
        chk(u_mem.wr_count == 2, "stray data writes");
        // Start held high through busy is taken once only
        run('{1'h1, 4'h0, 3'h0, 8'hFF, 8'h00, 16'h0000, 8'h00, 1'h1, 2'h2, 4'h4}, 0, 1'h1, n);
        chk(n == 4 && work_byte === 8'h00 && zero_flag === 1'h1, "held start");
        // Frozen clock enable stretches the count by the stall
        run('{1'h0, 4'h0, 3'h0, 8'h21, 8'h00, 16'h0000, 8'h21, 1'h0, 2'h2, 4'h4}, 3, 1'h0, n);
        chk(n == 7 && work_byte === 8'h21, "stalled instruction");
        refuse(4'h2, 3'h1);
        refuse(4'hA, 3'h0);
        // Second reset in mid-run
        @(negedge sys_clk);
        rst_n = 1'h0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'h1;
        chk(work_byte === 8'h00 && zero_flag === 1'h0 && busy === 1'h0, "second reset");
        run(ROWS[0], 0, 1'h0, n);
        chk(n == 4 && work_byte === 8'h10, "after second reset");
        complete_run();
    end
endmodule
